// ---- hw/ecm_pkg.sv ----
// Constants shared by the contact feedback monitor files.
// Assumes a 100 MHz system clock and an APB register bus with 32-bit data.
// Operation
// - Three monitor modes: one-channel, two-channel, none.
// - Two-channel mode is the reset default.
// - Monitored contacts open: refuse reset, outputs off.
// - One-channel: contact ignored while outputs on.
// - Two-channel: inputs changing together always accepted.
// - Two-channel: inputs opposite over 250 ms lock out.
// - Two-channel: diagnostics name the failing input.
// - One-channel with input a high acts unmonitored.
// - Open remote test forces safety outputs off.
// - Remote test obeys the test configuration bit.
// - Auxiliary output follows outputs or shows lockout.
// - Auxiliary output drives line b only one-channel.
// - Emitter fault output shows enabled emitter lockout.
package ecm_pkg;

  // Monitor configuration.
  typedef enum logic [1:0] {
    ECM_MODE_ONE  = 2'h0,
    ECM_MODE_TWO  = 2'h1,
    ECM_MODE_NONE = 2'h2
  } ecm_mode_type;

  // Safety output state.
  typedef enum logic [1:0] {
    ECM_ST_OFF,
    ECM_ST_ON,
    ECM_ST_LOCK
  } ecm_state_type;

  // Timing.
  localparam int unsigned CLK_HZ      = 100_000_000;
  localparam int unsigned TIMEOUT_MS  = 250;
  localparam int unsigned TIMEOUT_CYC = (CLK_HZ / 1000) * TIMEOUT_MS;

  // Register byte offsets.
  localparam logic [7:0] CTRL_OFS     = 8'h00;
  localparam logic [7:0] STATUS_OFS   = 8'h04;
  localparam logic [7:0] INT_STAT_OFS = 8'h08;
  localparam logic [7:0] INT_MASK_OFS = 8'h0c;

  // Control fields.
  localparam int CTRL_MODE_LSB  = 0;
  localparam int CTRL_AUXF_BIT  = 2;
  localparam int CTRL_TEST_BIT  = 3;
  localparam int CTRL_FLTEN_BIT = 4;
  localparam int CTRL_RESET_BIT = 8;

  // Interrupt event bits.
  localparam int EV_LOCK_BIT   = 0;
  localparam int EV_REFUSE_BIT = 1;
  localparam int EV_OFF_BIT    = 2;

  // Reset values.
  localparam ecm_mode_type MODE_RST = ECM_MODE_TWO;
  localparam logic         AUXF_RST  = 1'b0;
  localparam logic         TEST_RST  = 1'b1;
  localparam logic         FLTEN_RST = 1'b0;
  localparam logic [2:0]   MASK_RST  = 3'h0;

endpackage

// ---- hw/ecm_pins_if.sv ----
// Interface carrying the synchronised pin levels inside the monitor.
// Assumes both ends sit on the system clock.
`timescale 1ns/1ps
interface ecm_pins_if;
  logic fb_a;
  logic fb_b;
  logic test_ok;
  modport src (output fb_a, output fb_b, output test_ok);
  modport dst (input fb_a, input fb_b, input test_ok);
endinterface

// ---- hw/ecm_sync.sv ----
// Two-stage synchronisers for the contact and remote test pins.
// Assumes pins are asynchronous to i_mclk.
`timescale 1ns/1ps
module ecm_sync (
  // Clock and reset.
  input  wire logic i_mclk,
  input  wire logic i_resetn,
  // Raw pins.
  input  wire logic i_fb_a,
  input  wire logic i_fb_b,
  input  wire logic i_test,
  // Synchronised levels.
  ecm_pins_if.src   pins
);
  logic [2:0] meta_reg;
  logic [2:0] sync_reg;

  // The first stage is read only by the second stage.
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      meta_reg <= 3'h0;
      sync_reg <= 3'h0;
    end else begin
      meta_reg <= {i_test, i_fb_b, i_fb_a};
      sync_reg <= meta_reg;
    end
  end

  assign pins.fb_a    = sync_reg[0];
  assign pins.fb_b    = sync_reg[1];
  assign pins.test_ok = sync_reg[2];
endmodule // ecm_sync

// ---- hw/ecm_top.sv ----
// Contact feedback monitor: gates safety output turn-on, watches relay
// feedback contacts, drives the auxiliary and emitter fault outputs.
// Assumes beam clear and emitter lockout come from logic on i_mclk.
`timescale 1ns/1ps
module ecm_top #(
  parameter int unsigned P_TIMEOUT_CYC = ecm_pkg::TIMEOUT_CYC
) (
  // Clock and reset.
  input  wire logic        i_mclk,
  input  wire logic        i_resetn,
  // APB slave.
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // Feedback and test pins.
  input  wire logic        i_feedback_input_a,
  input  wire logic        i_feedback_input_b,
  input  wire logic        i_remote_test,
  // Same-clock status from scan logic.
  input  wire logic        i_beams_clear,
  input  wire logic        i_emitter_lockout,
  // Outputs.
  output logic             o_safety_switch_output,
  output logic             o_aux_out,
  output logic             o_aux_oe_n,
  output logic             o_emitter_fault,
  output logic             o_lockout,
  output logic             o_irq
);
  ecm_pins_if pins ();

  ecm_pkg::ecm_mode_type  mode_reg;
  ecm_pkg::ecm_state_type state_reg;
  ecm_pkg::ecm_state_type state_next;
  logic        auxf_reg;
  logic        test_en_reg;
  logic        flten_reg;
  logic        reset_cmd_reg;
  logic [2:0]  mask_reg;
  logic [2:0]  stat_reg;
  logic [1:0]  diag_reg;
  logic        safety_reg;
  logic        aux_reg;
  logic        aux_oe_n_reg;
  logic        fault_reg;
  logic [31:0] prdata_reg;
  logic        win_active_reg;
  logic [31:0] win_cnt_reg;
  logic [31:0] mis_cnt_reg;
  logic        contacts_ok;
  logic        test_force;
  logic        win_late;
  logic        mis_late;
  logic        fault_now;
  logic        wr_en;
  logic        rd_setup;
  logic        mapped;
  logic [2:0]  events;

  ecm_sync u_sync (
    .i_mclk   (i_mclk),
    .i_resetn (i_resetn),
    .i_fb_a   (i_feedback_input_a),
    .i_fb_b   (i_feedback_input_b),
    .i_test   (i_remote_test),
    .pins     (pins)
  );

  // Bus decode; the slave never stalls, so every access ends in one cycle.
  assign mapped   = (i_paddr == ecm_pkg::CTRL_OFS) || (i_paddr == ecm_pkg::STATUS_OFS) ||
                    (i_paddr == ecm_pkg::INT_STAT_OFS) || (i_paddr == ecm_pkg::INT_MASK_OFS);
  assign wr_en    = i_psel && i_penable && i_pwrite && mapped;
  assign rd_setup = i_psel && !i_penable && !i_pwrite;
  assign o_pready  = 1'b1;
  assign o_pslverr = i_psel && i_penable && !mapped;
  assign o_prdata  = prdata_reg;

  // Contact condition per mode; with input a tied high one-channel is unmonitored.
  always_comb begin
    unique case (mode_reg)
      ecm_pkg::ECM_MODE_ONE: contacts_ok = pins.fb_a;
      ecm_pkg::ECM_MODE_TWO: contacts_ok = pins.fb_a && pins.fb_b;
      default:               contacts_ok = 1'b1;
    endcase
  end

  // The test pin only acts when the test configuration bit enables it.
  assign test_force = test_en_reg && !pins.test_ok;
  assign win_late   = (mode_reg == ecm_pkg::ECM_MODE_ONE) && win_active_reg &&
                      (win_cnt_reg >= P_TIMEOUT_CYC) && !pins.fb_a;
  assign mis_late   = (mode_reg == ecm_pkg::ECM_MODE_TWO) &&
                      (mis_cnt_reg >= P_TIMEOUT_CYC);
  assign fault_now  = win_late || mis_late;

  // Next state of the safety outputs.
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ecm_pkg::ECM_ST_OFF: begin
        if (fault_now) begin
          state_next = ecm_pkg::ECM_ST_LOCK;
        end else if (reset_cmd_reg && contacts_ok && i_beams_clear && !test_force) begin
          state_next = ecm_pkg::ECM_ST_ON;
        end
      end
      ecm_pkg::ECM_ST_ON: begin
        // Contact changes are not looked at here in one-channel mode.
        if (mis_late) begin
          state_next = ecm_pkg::ECM_ST_LOCK;
        end else if (!i_beams_clear || test_force) begin
          state_next = ecm_pkg::ECM_ST_OFF;
        end
      end
      ecm_pkg::ECM_ST_LOCK: begin
        if (reset_cmd_reg && !fault_now && contacts_ok) begin
          state_next = ecm_pkg::ECM_ST_OFF;
        end
      end
    endcase
  end

  // State and safety output flip-flops.
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      state_reg  <= ecm_pkg::ECM_ST_OFF;
      safety_reg <= 1'b0;
    end else begin
      state_reg  <= state_next;
      safety_reg <= (state_next == ecm_pkg::ECM_ST_ON);
    end
  end

  // One-channel turn-off window: contacts must close before it runs out.
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      win_active_reg <= 1'b0;
      win_cnt_reg    <= 32'h0;
    end else if (state_reg == ecm_pkg::ECM_ST_ON && state_next != ecm_pkg::ECM_ST_ON) begin
      win_active_reg <= (mode_reg == ecm_pkg::ECM_MODE_ONE);
      win_cnt_reg    <= 32'h0;
    end else if (pins.fb_a || mode_reg != ecm_pkg::ECM_MODE_ONE || state_reg == ecm_pkg::ECM_ST_LOCK) begin
      win_active_reg <= 1'b0;
      win_cnt_reg    <= 32'h0;
    end else if (win_active_reg && win_cnt_reg < P_TIMEOUT_CYC) begin
      win_cnt_reg    <= win_cnt_reg + 32'h1;
    end
  end

  // Two-channel mismatch timer; equal inputs in any state reset it.
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      mis_cnt_reg <= 32'h0;
    end else if (mode_reg != ecm_pkg::ECM_MODE_TWO || pins.fb_a == pins.fb_b) begin
      mis_cnt_reg <= 32'h0;
    end else if (mis_cnt_reg < P_TIMEOUT_CYC) begin
      mis_cnt_reg <= mis_cnt_reg + 32'h1;
    end
  end

  // Diagnostics record which input stayed open when a lockout struck.
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      diag_reg <= 2'h0;
    end else if (state_reg != ecm_pkg::ECM_ST_LOCK && state_next == ecm_pkg::ECM_ST_LOCK) begin
      diag_reg <= {!pins.fb_b, !pins.fb_a};
    end else if (state_reg == ecm_pkg::ECM_ST_LOCK && state_next == ecm_pkg::ECM_ST_OFF) begin
      diag_reg <= 2'h0;
    end
  end

  // Auxiliary and emitter fault outputs; line b is only driven in one-channel mode.
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      aux_reg      <= 1'b0;
      aux_oe_n_reg <= 1'b1;
      fault_reg    <= 1'b0;
    end else begin
      aux_reg      <= auxf_reg ? (state_next == ecm_pkg::ECM_ST_LOCK)
                               : (state_next == ecm_pkg::ECM_ST_ON);
      aux_oe_n_reg <= (mode_reg != ecm_pkg::ECM_MODE_ONE);
      fault_reg    <= flten_reg && i_emitter_lockout;
    end
  end

  assign o_safety_switch_output = safety_reg;
  assign o_aux_out              = aux_reg;
  assign o_aux_oe_n             = aux_oe_n_reg;
  assign o_emitter_fault        = fault_reg;
  assign o_lockout              = (state_reg == ecm_pkg::ECM_ST_LOCK);

  // Control register; the reset command bit is a one-cycle pulse.
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      mode_reg      <= ecm_pkg::MODE_RST;
      auxf_reg      <= ecm_pkg::AUXF_RST;
      test_en_reg   <= ecm_pkg::TEST_RST;
      flten_reg     <= ecm_pkg::FLTEN_RST;
      mask_reg      <= ecm_pkg::MASK_RST;
      reset_cmd_reg <= 1'b0;
    end else begin
      reset_cmd_reg <= 1'b0;
      if (wr_en && i_paddr == ecm_pkg::CTRL_OFS) begin
        // Code 3 is illegal and falls back to no monitoring.
        if (i_pwdata[ecm_pkg::CTRL_MODE_LSB +: 2] == 2'h3) begin
          mode_reg <= ecm_pkg::ECM_MODE_NONE;
        end else begin
          mode_reg <= ecm_pkg::ecm_mode_type'(i_pwdata[ecm_pkg::CTRL_MODE_LSB +: 2]);
        end
        auxf_reg      <= i_pwdata[ecm_pkg::CTRL_AUXF_BIT];
        test_en_reg   <= i_pwdata[ecm_pkg::CTRL_TEST_BIT];
        flten_reg     <= i_pwdata[ecm_pkg::CTRL_FLTEN_BIT];
        reset_cmd_reg <= i_pwdata[ecm_pkg::CTRL_RESET_BIT];
      end
      if (wr_en && i_paddr == ecm_pkg::INT_MASK_OFS) begin
        mask_reg <= i_pwdata[2:0];
      end
    end
  end

  // Sticky events; a new event wins over a write-one clear in the same cycle.
  assign events[ecm_pkg::EV_LOCK_BIT]   = (state_reg != ecm_pkg::ECM_ST_LOCK) &&
                                          (state_next == ecm_pkg::ECM_ST_LOCK);
  assign events[ecm_pkg::EV_REFUSE_BIT] = reset_cmd_reg && (state_next == state_reg) &&
                                          (state_reg != ecm_pkg::ECM_ST_ON);
  assign events[ecm_pkg::EV_OFF_BIT]    = (state_reg == ecm_pkg::ECM_ST_ON) &&
                                          (state_next != ecm_pkg::ECM_ST_ON);

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      stat_reg <= 3'h0;
    end else if (wr_en && i_paddr == ecm_pkg::INT_STAT_OFS) begin
      stat_reg <= (stat_reg & ~i_pwdata[2:0]) | events;
    end else begin
      stat_reg <= stat_reg | events;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(stat_reg & mask_reg);
    end
  end

  // Read data is captured in the setup cycle so it is stable for the access.
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      prdata_reg <= 32'h0;
    end else if (rd_setup) begin
      unique case (i_paddr)
        ecm_pkg::CTRL_OFS:     prdata_reg <= {27'h0, flten_reg, test_en_reg, auxf_reg, mode_reg};
        ecm_pkg::STATUS_OFS:   prdata_reg <= {24'h0, pins.test_ok, pins.fb_b, pins.fb_a,
                                              diag_reg, safety_reg, state_reg};
        ecm_pkg::INT_STAT_OFS: prdata_reg <= {29'h0, stat_reg};
        ecm_pkg::INT_MASK_OFS: prdata_reg <= {29'h0, mask_reg};
        default:               prdata_reg <= 32'h0;
      endcase
    end
  end

  // Checks on the monitor behaviour.
  sequence s_reset_try;
    state_reg == ecm_pkg::ECM_ST_OFF && reset_cmd_reg;
  endsequence

  sequence s_turn_off;
    state_reg == ecm_pkg::ECM_ST_ON && !i_beams_clear;
  endsequence

  property p_default_mode;
    @(posedge i_mclk) !i_resetn |=> mode_reg == ecm_pkg::ECM_MODE_TWO;
  endproperty
  a_default_mode: assert property (p_default_mode) else $error("Mode after reset is not two-channel.");

  property p_refuse;
    @(posedge i_mclk) disable iff (!i_resetn)
      s_reset_try ##0 !contacts_ok |=> !o_safety_switch_output ##1 !o_safety_switch_output;
  endproperty
  a_refuse: assert property (p_refuse) else $error("Reset accepted with open contacts.");

  property p_one_ignore;
    @(posedge i_mclk) disable iff (!i_resetn)
      state_reg == ecm_pkg::ECM_ST_ON && mode_reg == ecm_pkg::ECM_MODE_ONE && i_beams_clear &&
      !test_force |=> o_safety_switch_output;
  endproperty
  a_one_ignore: assert property (p_one_ignore) else $error("One-channel output dropped by contact.");

  property p_win_lock;
    @(posedge i_mclk) disable iff (!i_resetn)
      win_late && state_reg == ecm_pkg::ECM_ST_OFF |=> o_lockout;
  endproperty
  a_win_lock: assert property (p_win_lock) else $error("Late contact did not lock out.");

  property p_agree;
    @(posedge i_mclk) disable iff (!i_resetn)
      mode_reg == ecm_pkg::ECM_MODE_TWO && pins.fb_a == pins.fb_b |=> mis_cnt_reg == 32'h0;
  endproperty
  a_agree: assert property (p_agree) else $error("Matching inputs counted as mismatch.");

  property p_mis_lock;
    @(posedge i_mclk) disable iff (!i_resetn)
      mis_late && state_reg != ecm_pkg::ECM_ST_LOCK |=> o_lockout && !o_safety_switch_output;
  endproperty
  a_mis_lock: assert property (p_mis_lock) else $error("Mismatch did not lock out.");

  // A lockout must latch: only an explicit reset command may take the monitor out of it.
  property p_lock_hold;
    @(posedge i_mclk) disable iff (!i_resetn)
      o_lockout && !reset_cmd_reg |=> o_lockout;
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("Lockout left without a reset command.");

  property p_test_off;
    @(posedge i_mclk) disable iff (!i_resetn)
      test_force |=> !o_safety_switch_output;
  endproperty
  a_test_off: assert property (p_test_off) else $error("Safety output on during remote test.");

  property p_beam_off;
    @(posedge i_mclk) disable iff (!i_resetn)
      s_turn_off |=> !o_safety_switch_output ##0 stat_reg[ecm_pkg::EV_OFF_BIT];
  endproperty
  a_beam_off: assert property (p_beam_off) else $error("Turn-off not seen at output.");

  property p_aux_line;
    @(posedge i_mclk) disable iff (!i_resetn)
      mode_reg != ecm_pkg::ECM_MODE_ONE |=> o_aux_oe_n;
  endproperty
  a_aux_line: assert property (p_aux_line) else $error("Auxiliary driven outside one-channel.");

  property p_aux_fault;
    @(posedge i_mclk) disable iff (!i_resetn)
      auxf_reg && $stable(auxf_reg) && o_lockout |-> o_aux_out;
  endproperty
  a_aux_fault: assert property (p_aux_fault) else $error("Auxiliary fault not shown.");

  property p_emit_fault;
    @(posedge i_mclk) disable iff (!i_resetn)
      !flten_reg |=> !o_emitter_fault;
  endproperty
  a_emit_fault: assert property (p_emit_fault) else $error("Emitter fault shown while disabled.");

endmodule // ecm_top

// ---- testbench/ecm_contact_model.sv ----
// Behavioural model of the relay feedback contacts and the remote test switch.
// Assumes the bench changes its controls just after rising edges of i_mclk.
`timescale 1ns/1ps
module ecm_contact_model (
  // Clock.
  input  wire logic       i_mclk,
  // Coil drive and fault controls.
  input  wire logic       i_safety,
  input  wire logic [5:0] i_delay_a,
  input  wire logic [5:0] i_delay_b,
  input  wire logic       i_weld_a,
  input  wire logic       i_test_open,
  // Contact and switch levels, high = closed.
  output logic            o_fb_a,
  output logic            o_fb_b,
  output logic            o_test
);
  logic       a_reg = 1'h1;
  logic       b_reg = 1'h1;
  logic [5:0] cnt_a = 6'h00;
  logic [5:0] cnt_b = 6'h00;

  // Each N.C. contact follows the inverse of the coil after its own delay, so slow elements can be modelled.
  always_ff @(posedge i_mclk) begin
    if (a_reg == i_safety) begin
      cnt_a <= (cnt_a >= i_delay_a) ? 6'h00 : cnt_a + 6'h01;
      if (cnt_a >= i_delay_a) a_reg <= ~i_safety;
    end else cnt_a <= 6'h00;
  end

  // Channel b has an independent delay, so the two channels move apart whenever the two delays differ.
  always_ff @(posedge i_mclk) begin
    if (b_reg == i_safety) begin
      cnt_b <= (cnt_b >= i_delay_b) ? 6'h00 : cnt_b + 6'h01;
      if (cnt_b >= i_delay_b) b_reg <= ~i_safety;
    end else cnt_b <= 6'h00;
  end

  // A welded contact never closes again; the switch is closed in normal use.
  assign o_fb_a = a_reg & ~i_weld_a;
  assign o_fb_b = b_reg;
  assign o_test = ~i_test_open;
endmodule // ecm_contact_model

// ---- testbench/test_ecm_top.sv ----
// Self-checking bench for the contact feedback monitor top level.
// Assumes the contact model sits on the feedback pins and the bench is the APB master.
`timescale 1ns/1ps
module test_ecm_top;
  typedef struct {
    string       n;
    logic [32:0] e;
    logic [32:0] m;
  } ecm_note_type;

  localparam int unsigned P_TO  = 20;
  localparam logic [5:0]  B_SAFE = 6'h20, B_AUX = 6'h10, B_OEN = 6'h08;
  localparam logic [5:0]  B_EF   = 6'h04, B_LK = 6'h02, B_IRQ = 6'h01;
  localparam logic [32:0] ALL    = {33{1'h1}};

  logic         mclk = 1'h0, rst_n = 1'h0, look = 1'h0;
  logic         psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0]   paddr = 8'h00;
  logic [31:0]  pwdata = 32'h0, prdata;
  logic         pready, pslverr, safety, aux, aux_oe_n, efault, lock, irq;
  logic         beams = 1'h1, emit_lk = 1'h0, weld = 1'h0, test_open = 1'h0, hi_a = 1'h0, tie_ab = 1'h0;
  logic         m_a, m_b, m_test, fb_a, fb_b;
  logic [5:0]   dly_a = 6'h01, dly_b = 6'h01;
  logic [5:0]   outs;
  int           errors = 0, checks_done = 0;
  ecm_note_type notes[$];
  ecm_note_type nt;

  // Unless tie_ab ties it to line a, line b carries the auxiliary output when the device enables it, else the contact.
  assign fb_a = hi_a | m_a;
  assign fb_b = tie_ab ? fb_a : (aux_oe_n ? m_b : aux);
  assign outs = {safety, aux, aux_oe_n, efault, lock, irq};

  always #5 mclk = ~mclk;

  ecm_top #(.P_TIMEOUT_CYC(P_TO)) dut (
    .i_mclk(mclk), .i_resetn(rst_n), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_feedback_input_a(fb_a), .i_feedback_input_b(fb_b), .i_remote_test(m_test),
    .i_beams_clear(beams), .i_emitter_lockout(emit_lk), .o_safety_switch_output(safety),
    .o_aux_out(aux), .o_aux_oe_n(aux_oe_n), .o_emitter_fault(efault), .o_lockout(lock), .o_irq(irq));

  ecm_contact_model partner (
    .i_mclk(mclk), .i_safety(safety), .i_delay_a(dly_a), .i_delay_b(dly_b), .i_weld_a(weld),
    .i_test_open(test_open), .o_fb_a(m_a), .o_fb_b(m_b), .o_test(m_test));

  task automatic check(input string n, input logic [32:0] seen, input logic [32:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("Checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // One APB transfer; a read leaves its expected word and error flag as a note.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e,
                     input logic [32:0] m);
    int n;
    n = 0;
    @(posedge mclk);
    if (!w) notes.push_back('{$sformatf("read %h", a), e, m});
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1) begin
      errors++;
      report_and_stop();
    end
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  // Leaves a note for the output pins and asks the monitor to look for one cycle.
  task automatic peek(input string n, input logic [5:0] e, input logic [5:0] m);
    @(posedge mclk);
    notes.push_back('{n, {27'h0, e}, {27'h0, m}});
    look <= 1'h1;
    @(posedge mclk);
    look <= 1'h0;
  endtask

  // Bounded wait on the falling edge, where registered outputs have settled; returns just after a rising edge.
  task automatic wait_out(input logic [5:0] b, input logic v);
    int n;
    n = 0;
    @(negedge mclk);
    while ((|(outs & b)) !== v && n < 100) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 100) begin
      errors++;
      report_and_stop();
    end
    @(posedge mclk);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // Results are compared in the low half of the cycle, never on the edge that launches them.
  always @(negedge mclk) begin
    if ((psel && penable && !pwrite && pready) || look) begin
      if (notes.size() == 0) begin
        check("note queue", 33'h0, 33'h1);
      end else begin
        nt = notes.pop_front();
        check(nt.n, (look ? {27'h0, outs} : {pslverr, prdata}) & nt.m, nt.e & nt.m);
      end
    end
  end

  initial begin
    void'($urandom(32'hf5a432ce));
    dly_a = 6'($urandom_range(1, 4));
    dly_b = 6'($urandom_range(1, 4));
    cyc(2);
    rst_n <= 1'h1;
    cyc(3);
    // Reset values, an unmapped place and the idle pins.
    apb(1'h0, ecm_pkg::CTRL_OFS, 32'h0, 33'h9, ALL);
    apb(1'h0, ecm_pkg::INT_MASK_OFS, 32'h0, 33'h0, ALL);
    apb(1'h0, 8'h10, 32'h0, 33'h1_0000_0000, ALL);
    peek("idle pins", B_OEN, 6'h3f);
    // Two-channel: both contacts move together while on and after a trip.
    apb(1'h1, ecm_pkg::CTRL_OFS, 32'h109, 33'h0, 33'h0);
    wait_out(B_SAFE, 1'h1);
    cyc(P_TO + 10);
    peek("two-channel on", B_SAFE | B_OEN, B_SAFE | B_OEN | B_LK);
    beams <= 1'h0;
    wait_out(B_SAFE, 1'h0);
    cyc(P_TO + 10);
    peek("two-channel off", 6'h0, B_SAFE | B_LK);
    beams <= 1'h1;
    // Welded contact a: no lockout inside the timeout, lockout after it, reset refused.
    weld <= 1'h1;
    cyc(P_TO / 2);
    peek("mismatch inside timeout", 6'h0, B_LK);
    wait_out(B_LK, 1'h1);
    peek("masked irq", B_LK, B_LK | B_IRQ);
    apb(1'h0, ecm_pkg::STATUS_OFS, 32'h0, 33'h0a, 33'h1b);
    apb(1'h1, ecm_pkg::CTRL_OFS, 32'h109, 33'h0, 33'h0);
    apb(1'h0, ecm_pkg::INT_STAT_OFS, 32'h0, 33'h3, 33'h3);
    apb(1'h1, ecm_pkg::INT_MASK_OFS, 32'h1, 33'h0, 33'h0);
    peek("unmasked irq", B_LK | B_IRQ, B_SAFE | B_LK | B_IRQ);
    apb(1'h1, ecm_pkg::INT_STAT_OFS, 32'h3, 33'h0, 33'h0);
    peek("cleared irq", B_LK, B_LK | B_IRQ);
    weld <= 1'h0;
    cyc(5);
    apb(1'h1, ecm_pkg::CTRL_OFS, 32'h109, 33'h0, 33'h0);
    wait_out(B_LK, 1'h0);
    peek("lockout left to off", 6'h0, B_SAFE | B_LK);
    apb(1'h1, ecm_pkg::CTRL_OFS, 32'h109, 33'h0, 33'h0);
    wait_out(B_SAFE, 1'h1);
    // Remote test forces off when enabled and is ignored when disabled.
    test_open <= 1'h1;
    wait_out(B_SAFE, 1'h0);
    test_open <= 1'h0;
    cyc(5);
    apb(1'h1, ecm_pkg::CTRL_OFS, 32'h101, 33'h0, 33'h0);
    wait_out(B_SAFE, 1'h1);
    test_open <= 1'h1;
    cyc(10);
    peek("test ignored", B_SAFE, B_SAFE);
    test_open <= 1'h0;
    beams <= 1'h0;
    wait_out(B_SAFE, 1'h0);
    cyc(P_TO);
    // One-channel: aux on line b, contact ignored while on, late closing locks out.
    beams <= 1'h1;
    apb(1'h1, ecm_pkg::CTRL_OFS, 32'h108, 33'h0, 33'h0);
    wait_out(B_SAFE, 1'h1);
    cyc(P_TO + 10);
    peek("one-channel on", B_SAFE | B_AUX, B_SAFE | B_AUX | B_OEN | B_LK);
    dly_a <= 6'h28;
    beams <= 1'h0;
    cyc(P_TO / 2);
    apb(1'h1, ecm_pkg::CTRL_OFS, 32'h108, 33'h0, 33'h0);
    peek("closing pending", 6'h0, B_SAFE | B_AUX | B_LK);
    apb(1'h0, ecm_pkg::INT_STAT_OFS, 32'h0, 33'h2, 33'h2);
    wait_out(B_LK, 1'h1);
    apb(1'h1, ecm_pkg::CTRL_OFS, 32'h00c, 33'h0, 33'h0);
    peek("aux shows fault", B_AUX | B_LK, B_AUX | B_OEN | B_LK);
    dly_a <= 6'($urandom_range(1, 4));
    cyc(50);
    beams <= 1'h1;
    apb(1'h1, ecm_pkg::CTRL_OFS, 32'h10c, 33'h0, 33'h0);
    wait_out(B_LK, 1'h0);
    peek("aux fault gone", 6'h0, B_AUX | B_LK);
    // One-channel with input a held closed acts unmonitored even with a slow contact.
    hi_a <= 1'h1;
    dly_a <= 6'h28;
    apb(1'h1, ecm_pkg::CTRL_OFS, 32'h108, 33'h0, 33'h0);
    wait_out(B_SAFE, 1'h1);
    beams <= 1'h0;
    cyc(P_TO + 10);
    peek("a held closed", 6'h0, B_SAFE | B_OEN | B_LK);
    cyc(P_TO);
    hi_a <= 1'h0;
    dly_a <= 6'h02;
    // No monitoring with tied open lines; then the emitter fault output.
    tie_ab <= 1'h1;
    weld <= 1'h1;
    beams <= 1'h1;
    apb(1'h1, ecm_pkg::CTRL_OFS, 32'h10b, 33'h0, 33'h0);
    wait_out(B_SAFE, 1'h1);
    apb(1'h0, ecm_pkg::CTRL_OFS, 32'h0, 33'h0a, ALL);
    cyc(P_TO + 10);
    peek("none mode on", B_SAFE | B_OEN, B_SAFE | B_OEN | B_LK);
    emit_lk <= 1'h1;
    apb(1'h1, ecm_pkg::CTRL_OFS, 32'h01a, 33'h0, 33'h0);
    peek("fault enabled", B_EF, B_EF);
    apb(1'h1, ecm_pkg::CTRL_OFS, 32'h00a, 33'h0, 33'h0);
    peek("fault disabled", 6'h0, B_EF);
    report_and_stop();
  end
endmodule // test_ecm_top
